/* tm_cfg.svh */
`ifndef TM_CFG_SVH
`define TM_CFG_SVH
// command byte addresses
`define TM_A_RT1   8'h01
`define TM_A_RT4   8'h04
`define TM_A_RSV0  8'h05
`define TM_A_RSV1  8'h06
`define TM_A_LOC   8'h07
`define TM_A_FRAC  8'h09
`define TM_A_ID    8'h0A
`define TM_A_AL1   8'h11
`define TM_A_AL4   8'h14
`define TM_A_ALR0  8'h15
`define TM_A_ALR1  8'h16
`define TM_A_ALL   8'h17
`define TM_A_OT1   8'h21
`define TM_A_OT4   8'h24
`define TM_A_OTR0  8'h25
`define TM_A_OTR1  8'h26
`define TM_A_CFG1  8'h41
`define TM_A_CFG2  8'h42
`define TM_A_CFG3  8'h43
`define TM_A_ST1   8'h44
`define TM_A_ST2   8'h45
`define TM_A_ST3   8'h46
// power-on values
`define TM_R_ZERO  8'h00
`define TM_R_ALL   8'h5A
`define TM_R_AL1   8'h6E
`define TM_R_AL2   8'h7F
`define TM_R_AL3   8'h64
`define TM_R_AL4   8'h64
`define TM_R_OT1   8'h6E
`define TM_R_OT4   8'h7F
`define TM_R_ALR   8'h64
`define TM_R_OTR   8'h5A
// result encoding and alarm figures
`define TM_T_MAX   8'h7F
`define TM_T_OPEN  8'hFF
`define TM_HYST    9'h004
// field positions
`define TM_C1_STOP 7
`define TM_C1_POR  6
`define TM_C1_TOD  5
`define TM_C1_FAST 4
`define TM_ST1_LOC 6
`define TM_OT_CH1  0
`define TM_OT_CH4  3
`define TM_OT_MASK 8'h09
// channel indices, remote 1..4 then local
`define TM_CH_R1   3'h0
`define TM_CH_R4   3'h3
`define TM_CH_LOC  3'h4
// bus and timing
`define TM_ARA     7'h0C
`define TM_CLK_NS  4
`define TM_TOUT_NS 37000000
`define TM_FLT_NS  4000000
`endif

/* tm_pkg.sv */
package tm_pkg;
    typedef enum logic [2:0] {BS_IDLE, BS_RX, BS_ACK, BS_TX, BS_MACK}
        tm_bus_st_t;
    typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_DATA} tm_phase_t;
    typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_FAULT} tm_seq_st_t;
endpackage

/* tm_smbus_regs.sv */
// Overview of operation
// - main results are whole degrees, clamped to 7Fh above, 00h below
// - channel 1 fraction sits in bits 7:5 of low byte, eighth steps
// - reading low byte freezes channel 1 high byte until read or timeout
// - an open or shorted diode stores FFh as the channel value
// - a diode fault sets that channel's fault status bit
// - an open diode never raises alert or overtemperature outputs
// - fault detection waits about 4ms, then goes to next channel
// - seven writable limits: five alert used, two overtemperature
// - alert asserts when a reading exceeds its channel's alert limit
// - status 1 read or alert response completion releases alert
// - alert reasserts at next conversion end if condition persists
// - alert never pauses the conversion sequence
// - alert pin is only pulled low, open drain
// - every alert source is maskable by configuration bits
// - temperature values at 07 and 01 to 04, read only, reset 00
// - channel 1 fraction readable at 09, reset 00
// - three configuration registers at 41 to 43, reset 00
// - three status registers at 44 to 46, read only, reset 00
// - limit registers reset to their listed values
// - maker code readable at 0A
// - receive byte returns register chosen by last command byte
// - overtemperature holds until reading drops below limit minus 4
`timescale 1ns/1ps
`include "tm_cfg.svh"
module tm_smbus_regs import tm_pkg::*; #(
    parameter logic [6:0] DEV_ADDR   = 7'h1A,
    parameter logic [7:0] MAKER_CODE = 8'h5C, // arbitrary value
    parameter int         TOUT_CYC   = `TM_TOUT_NS / `TM_CLK_NS,
    parameter int         FAULT_CYC  = `TM_FLT_NS / `TM_CLK_NS
) (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // smbus pins
    input  wire logic        smb_clk_i,
    input  wire logic        smb_data_i,
    output logic             smb_data_o,
    output logic             smb_data_oe_o,
    // alarm pins, open drain
    output logic             alert_o,
    output logic             alert_oe_o,
    output logic             over_temp_out_o,
    output logic             over_temp_out_oe_o,
    // measurement front end
    output logic             meas_start_o,
    output logic [2:0]       meas_chan_o,
    input  wire logic        meas_done_i,
    input  wire logic [11:0] meas_value_i,
    input  wire logic        meas_open_i,
    input  wire logic        meas_short_i
);
    localparam int CW = 24;

    logic [2:0]  scl_sy, sda_sy;
    logic        scl_f, sda_f, scl_q, sda_q;
    logic        start_ev, stop_ev, scl_rise, scl_fall;
    tm_bus_st_t  bs;
    tm_phase_t   ph;
    logic [2:0]  bcnt;
    logic        full;
    logic [7:0]  sh, tx, ptr;
    logic        is_rd, is_ara;
    logic [CW-1:0] tcnt;
    logic        bus_to, rd_fire, wr_fire, ara_done;
    logic [7:0]  rd_mux;
    logic [7:0]  temp_reg [5];
    logic [7:0]  alim_reg [5];
    logic [7:0]  frac_reg, otl1_reg, otl4_reg;
    logic [7:0]  cfg1_reg, cfg2_reg, cfg3_reg;
    logic [7:0]  st1_reg, st2_reg, st3_reg;
    logic        por_reg, reg_rst, lock_reg;
    logic [CW-1:0] lcnt;
    tm_seq_st_t  sq;
    logic [2:0]  sq_ch, sq_oth, nxt_ch, nxt_oth;
    logic [CW-1:0] fcnt;
    logic        conv_ev, fault, a_hit, a_mask, ot_ch;
    logic [7:0]  enc, ot_lim;
    logic [2:0]  s1_idx;
    logic [2:0]  ot_idx;

    // whole degrees from eighths, clamped
    function automatic logic [7:0] tm_enc(input logic [11:0] v);
        if (v[11])
            return `TM_R_ZERO;
        else if (v[11:3] > {1'b0, `TM_T_MAX})
            return `TM_T_MAX;
        else
            return v[10:3];
    endfunction

    // three-flop pin sampling, change taken when stages 2 and 3 agree
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            scl_sy <= 3'h7;
            sda_sy <= 3'h7;
            scl_f  <= 1'b1;
            sda_f  <= 1'b1;
            scl_q  <= 1'b1;
            sda_q  <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[1:0], smb_clk_i};
            sda_sy <= {sda_sy[1:0], smb_data_i};
            if (scl_sy[2] == scl_sy[1])
                scl_f <= scl_sy[2];
            if (sda_sy[2] == sda_sy[1])
                sda_f <= sda_sy[2];
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    assign start_ev = scl_f && scl_q && sda_q && !sda_f;
    assign stop_ev  = scl_f && scl_q && !sda_q && sda_f;
    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;
    assign bus_to   = !cfg1_reg[`TM_C1_TOD] && tcnt == CW'(TOUT_CYC - 1);
    // reads take effect when the byte is loaded for sending
    assign rd_fire  = bs == BS_ACK && scl_fall && is_rd && !is_ara;
    assign wr_fire  = bs == BS_RX && scl_fall && full && ph == PH_DATA;
    assign ara_done = bs == BS_MACK && scl_rise && is_ara;

    // clock-low timeout frees a stuck bus
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || scl_f || bus_to)
            tcnt <= '0;
        else
            tcnt <= tcnt + CW'(1);
    end

    // smbus slave byte engine
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            bs            <= BS_IDLE;
            ph            <= PH_ADDR;
            bcnt          <= 3'h0;
            full          <= 1'b0;
            sh            <= 8'h00;
            tx            <= 8'h00;
            ptr           <= `TM_R_ZERO;
            is_rd         <= 1'b0;
            is_ara        <= 1'b0;
            smb_data_oe_o <= 1'b0;
        end else if (start_ev) begin
            // repeated start keeps the pointer
            bs            <= BS_RX;
            ph            <= PH_ADDR;
            bcnt          <= 3'h0;
            full          <= 1'b0;
            smb_data_oe_o <= 1'b0;
        end else if (stop_ev || bus_to) begin
            bs            <= BS_IDLE;
            smb_data_oe_o <= 1'b0;
        end else begin
            case (bs)
                BS_RX: begin
                    if (scl_rise) begin
                        sh   <= {sh[6:0], sda_f};
                        bcnt <= bcnt + 3'h1;
                        full <= bcnt == 3'h7;
                    end else if (scl_fall && full) begin
                        full <= 1'b0;
                        if (ph == PH_ADDR) begin
                            is_rd  <= sh[0];
                            is_ara <= sh[7:1] == `TM_ARA;
                            if (sh[7:1] == DEV_ADDR) begin
                                ph            <= PH_CMD;
                                bs            <= BS_ACK;
                                smb_data_oe_o <= 1'b1;
                            end else if (sh[7:1] == `TM_ARA && sh[0]
                                         && alert_oe_o) begin
                                bs            <= BS_ACK;
                                smb_data_oe_o <= 1'b1;
                            end else begin
                                bs <= BS_IDLE;
                            end
                        end else begin
                            if (ph == PH_CMD)
                                ptr <= sh;
                            ph            <= PH_DATA;
                            bs            <= BS_ACK;
                            smb_data_oe_o <= 1'b1;
                        end
                    end
                end
                BS_ACK: begin
                    if (scl_fall) begin
                        bcnt <= 3'h0;
                        if (is_rd) begin
                            tx            <= is_ara ? {DEV_ADDR, 1'b0}
                                                    : rd_mux;
                            smb_data_oe_o <= is_ara ? !DEV_ADDR[6]
                                                    : !rd_mux[7];
                            bs            <= BS_TX;
                        end else begin
                            smb_data_oe_o <= 1'b0;
                            bs            <= BS_RX;
                        end
                    end
                end
                BS_TX: begin
                    // losing arbitration on the alert response
                    if (scl_rise && is_ara && !smb_data_oe_o && !sda_f) begin
                        bs <= BS_IDLE;
                    end else if (scl_fall) begin
                        bcnt <= bcnt + 3'h1;
                        tx   <= {tx[6:0], 1'b0};
                        if (bcnt == 3'h7) begin
                            smb_data_oe_o <= 1'b0;
                            bs            <= BS_MACK;
                        end else begin
                            smb_data_oe_o <= !tx[6];
                        end
                    end
                end
                BS_MACK: begin
                    // host leaves the last byte unacknowledged
                    if (scl_rise)
                        bs <= (sda_f || is_ara) ? BS_IDLE : BS_ACK;
                end
                default: bs <= BS_IDLE;
            endcase
        end
    end

    // register read mux, reserved slots answer their reset values
    always_comb begin
        if (ptr >= `TM_A_RT1 && ptr <= `TM_A_RT4)
            rd_mux = temp_reg[3'(ptr - `TM_A_RT1)];
        else if (ptr == `TM_A_LOC)
            rd_mux = temp_reg[`TM_CH_LOC];
        else if (ptr == `TM_A_FRAC)
            rd_mux = frac_reg;
        else if (ptr == `TM_A_ID)
            rd_mux = MAKER_CODE;
        else if (ptr >= `TM_A_AL1 && ptr <= `TM_A_AL4)
            rd_mux = alim_reg[3'(ptr - `TM_A_AL1)];
        else if (ptr == `TM_A_ALR0 || ptr == `TM_A_ALR1)
            rd_mux = `TM_R_ALR;
        else if (ptr == `TM_A_ALL)
            rd_mux = alim_reg[`TM_CH_LOC];
        else if (ptr == `TM_A_OT1)
            rd_mux = otl1_reg;
        else if (ptr == `TM_A_OT4)
            rd_mux = otl4_reg;
        else if (ptr == `TM_A_OTR0 || ptr == `TM_A_OTR1)
            rd_mux = `TM_R_OTR;
        else if (ptr == `TM_A_CFG1)
            rd_mux = cfg1_reg;
        else if (ptr == `TM_A_CFG2)
            rd_mux = cfg2_reg;
        else if (ptr == `TM_A_CFG3)
            rd_mux = cfg3_reg;
        else if (ptr == `TM_A_ST1)
            rd_mux = st1_reg;
        else if (ptr == `TM_A_ST2)
            rd_mux = st2_reg;
        else if (ptr == `TM_A_ST3)
            rd_mux = st3_reg;
        else
            rd_mux = `TM_R_ZERO;
    end

    // conversion result decode
    assign conv_ev = sq == SQ_WAIT && meas_done_i && !cfg1_reg[`TM_C1_STOP];
    // the local sensor has no diode, so no fault can be flagged on it
    assign fault   = (meas_open_i || meas_short_i) && sq_ch != `TM_CH_LOC;
    assign enc     = fault ? `TM_T_OPEN : tm_enc(meas_value_i);
    assign s1_idx  = sq_ch == `TM_CH_LOC ? 3'(`TM_ST1_LOC) : sq_ch;
    assign a_hit   = !fault && enc > alim_reg[sq_ch];
    assign a_mask  = cfg2_reg[s1_idx];
    assign ot_ch   = sq_ch == `TM_CH_R1 || sq_ch == `TM_CH_R4;
    assign ot_lim  = sq_ch == `TM_CH_R1 ? otl1_reg : otl4_reg;
    assign ot_idx  = sq_ch == `TM_CH_R1 ? 3'(`TM_OT_CH1) : 3'(`TM_OT_CH4);
    assign reg_rst = !rst_n_i || por_reg;

    // soft reset pulse from the configuration write
    always_ff @(posedge clock_i) begin
        if (!rst_n_i)
            por_reg <= 1'b0;
        else
            por_reg <= wr_fire && ptr == `TM_A_CFG1 && sh[`TM_C1_POR];
    end

    // writable registers
    always_ff @(posedge clock_i) begin
        if (reg_rst) begin
            cfg1_reg                <= `TM_R_ZERO;
            cfg2_reg                <= `TM_R_ZERO;
            cfg3_reg                <= `TM_R_ZERO;
            alim_reg[0]             <= `TM_R_AL1;
            alim_reg[1]             <= `TM_R_AL2;
            alim_reg[2]             <= `TM_R_AL3;
            alim_reg[3]             <= `TM_R_AL4;
            alim_reg[`TM_CH_LOC]    <= `TM_R_ALL;
            otl1_reg                <= `TM_R_OT1;
            otl4_reg                <= `TM_R_OT4;
        end else if (wr_fire) begin
            if (ptr == `TM_A_CFG1) begin
                cfg1_reg              <= sh;
                cfg1_reg[`TM_C1_POR]  <= 1'b0;  // self clearing
            end else if (ptr == `TM_A_CFG2)
                cfg2_reg <= sh;
            else if (ptr == `TM_A_CFG3)
                cfg3_reg <= sh;
            else if (ptr >= `TM_A_AL1 && ptr <= `TM_A_AL4)
                alim_reg[3'(ptr - `TM_A_AL1)] <= sh;
            else if (ptr == `TM_A_ALL)
                alim_reg[`TM_CH_LOC] <= sh;
            else if (ptr == `TM_A_OT1)
                otl1_reg <= sh;
            else if (ptr == `TM_A_OT4)
                otl4_reg <= sh;
        end
    end

    // high byte hold after the fraction is read
    always_ff @(posedge clock_i) begin
        if (reg_rst) begin
            lock_reg <= 1'b0;
            lcnt     <= '0;
        end else if (rd_fire && ptr == `TM_A_FRAC) begin
            lock_reg <= 1'b1;
            lcnt     <= '0;
        end else if (rd_fire && ptr == `TM_A_RT1) begin
            lock_reg <= 1'b0;
        end else if (lock_reg) begin
            lcnt <= lcnt + CW'(1);
            if (lcnt == CW'(TOUT_CYC - 1))
                lock_reg <= 1'b0;
        end
    end

    // temperature results
    always_ff @(posedge clock_i) begin
        if (reg_rst) begin
            for (int i = 0; i < 5; i++)
                temp_reg[i] <= `TM_R_ZERO;
            frac_reg <= `TM_R_ZERO;
        end else if (conv_ev && !(lock_reg && sq_ch == `TM_CH_R1)) begin
            temp_reg[sq_ch] <= enc;
            if (sq_ch == `TM_CH_R1)
                frac_reg <= fault ? `TM_R_ZERO
                                  : {meas_value_i[2:0], 5'h00};
        end
    end

    // status flags; a hit in the clearing cycle wins over the read
    always_ff @(posedge clock_i) begin
        if (reg_rst) begin
            st1_reg <= `TM_R_ZERO;
            st2_reg <= `TM_R_ZERO;
            st3_reg <= `TM_R_ZERO;
        end else begin
            if (rd_fire && ptr == `TM_A_ST1)
                st1_reg <= `TM_R_ZERO;
            if (conv_ev && a_hit)
                st1_reg[s1_idx] <= 1'b1;
            if (conv_ev && ot_ch && !fault) begin
                if (enc > ot_lim)
                    st2_reg[ot_idx] <= 1'b1;
                else if ({1'b0, enc} + `TM_HYST < {1'b0, ot_lim})
                    st2_reg[ot_idx] <= 1'b0;
            end
            if (conv_ev && sq_ch != `TM_CH_LOC)
                st3_reg[sq_ch] <= fault;
        end
    end

    // alarm pins, low drive only; outputs carry a constant zero
    always_ff @(posedge clock_i) begin
        if (reg_rst) begin
            alert_oe_o         <= 1'b0;
            over_temp_out_oe_o <= 1'b0;
        end else begin
            if (conv_ev && a_hit && !a_mask)
                alert_oe_o <= 1'b1;
            else if (ara_done || (rd_fire && ptr == `TM_A_ST1))
                alert_oe_o <= 1'b0;
            over_temp_out_oe_o <= |(st2_reg & ~cfg3_reg & `TM_OT_MASK);
        end
    end

    always_ff @(posedge clock_i) begin
        smb_data_o      <= 1'b0;
        alert_o         <= 1'b0;
        over_temp_out_o <= 1'b0;
    end

    // next channel, fast mode interleaves channel 1
    always_comb begin
        nxt_ch  = sq_ch == `TM_CH_LOC ? `TM_CH_R1 : sq_ch + 3'h1;
        nxt_oth = sq_oth;
        if (cfg1_reg[`TM_C1_FAST]) begin
            if (sq_ch == `TM_CH_R1) begin
                nxt_ch  = sq_oth == `TM_CH_LOC ? 3'h1 : sq_oth + 3'h1;
                nxt_oth = nxt_ch;
            end else begin
                nxt_ch  = `TM_CH_R1;
            end
        end
    end

    // conversion sequencer; alert state is not an input here
    always_ff @(posedge clock_i) begin
        if (reg_rst) begin
            sq           <= SQ_IDLE;
            sq_ch        <= `TM_CH_R1;
            sq_oth       <= `TM_CH_LOC;
            fcnt         <= '0;
            meas_start_o <= 1'b0;
            meas_chan_o  <= `TM_CH_R1;
        end else begin
            meas_start_o <= 1'b0;
            case (sq)
                SQ_IDLE: begin
                    if (!cfg1_reg[`TM_C1_STOP]) begin
                        meas_start_o <= 1'b1;
                        meas_chan_o  <= sq_ch;
                        sq           <= SQ_WAIT;
                    end
                end
                SQ_WAIT: begin
                    // standby drops the conversion in flight
                    if (cfg1_reg[`TM_C1_STOP]) begin
                        sq <= SQ_IDLE;
                    end else if (meas_done_i && fault) begin
                        fcnt <= '0;
                        sq   <= SQ_FAULT;
                    end else if (meas_done_i) begin
                        sq_ch  <= nxt_ch;
                        sq_oth <= nxt_oth;
                        sq     <= SQ_IDLE;
                    end
                end
                SQ_FAULT: begin
                    fcnt <= fcnt + CW'(1);
                    if (fcnt == CW'(FAULT_CYC - 1)) begin
                        sq_ch  <= nxt_ch;
                        sq_oth <= nxt_oth;
                        sq     <= SQ_IDLE;
                    end
                end
                default: sq <= SQ_IDLE;
            endcase
        end
    end

    property p_clamp;
        @(posedge clock_i) disable iff (!rst_n_i)
        temp_reg[`TM_CH_LOC] <= `TM_T_MAX;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("local result above clamp");

    property p_frac_low;
        @(posedge clock_i) disable iff (!rst_n_i)
        conv_ev && sq_ch == `TM_CH_R1 && !lock_reg && !fault |=>
            frac_reg == {3'($past(meas_value_i)), 5'h00};
    endproperty
    a_frac_low: assert property (p_frac_low)
        else $error("fraction byte wrong");

    property p_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        lock_reg && !por_reg |=> $stable(temp_reg[`TM_CH_R1]);
    endproperty
    a_hold: assert property (p_hold)
        else $error("held high byte changed");

    property p_open_val;
        @(posedge clock_i) disable iff (!rst_n_i)
        conv_ev && sq_ch == 3'h1 && meas_open_i |=>
            temp_reg[1] == `TM_T_OPEN && st3_reg[1];
    endproperty
    a_open_val: assert property (p_open_val)
        else $error("open diode not recorded");

    property p_open_quiet;
        @(posedge clock_i) disable iff (!rst_n_i)
        conv_ev && fault && !alert_oe_o |=> !alert_oe_o;
    endproperty
    a_open_quiet: assert property (p_open_quiet)
        else $error("open diode raised alert");

    property p_fault_wait;
        @(posedge clock_i) disable iff (!rst_n_i)
        conv_ev && fault |=> sq == SQ_FAULT ##1 sq == SQ_FAULT;
    endproperty
    a_fault_wait: assert property (p_fault_wait)
        else $error("fault wait skipped");

    property p_alert_set;
        @(posedge clock_i) disable iff (!rst_n_i)
        conv_ev && a_hit && !a_mask |=> alert_oe_o && st1_reg[$past(s1_idx)];
    endproperty
    a_alert_set: assert property (p_alert_set)
        else $error("alert not raised");

    property p_alert_clr;
        @(posedge clock_i) disable iff (!rst_n_i)
        rd_fire && ptr == `TM_A_ST1 && !conv_ev |=> !alert_oe_o;
    endproperty
    a_alert_clr: assert property (p_alert_clr)
        else $error("alert not released");

    property p_hyst;
        @(posedge clock_i) disable iff (!rst_n_i)
        conv_ev && sq_ch == `TM_CH_R1 && !fault && st2_reg[`TM_OT_CH1] &&
            {1'b0, enc} + `TM_HYST >= {1'b0, otl1_reg} |=>
            st2_reg[`TM_OT_CH1];
    endproperty
    a_hyst: assert property (p_hyst)
        else $error("overtemperature dropped inside hysteresis");
endmodule

/* tm_host.sv */
`timescale 1ns/1ps
module tm_host #(
    parameter logic [6:0] ADDR = 7'h1A
) (
    // bus pins, released high
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // data moves only while the clock is low; the long low phase leaves
    // room for the slave's filtered answer before the next rise
    task automatic bx(input logic b, output logic r);
        #12 sda_o = b;
        #12 scl_o = 1'b1;
        #8 r = sda_i;
        scl_o = 1'b0;
    endtask
    // msb first, ninth clock for ack
    task automatic by(input logic [7:0] d, output logic [7:0] q);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bx(d[i], r);
            q[i] = r;
        end
        bx(1'b1, r);
    endtask
    // wait for the slave to let go of an ack before raising the clock
    task automatic st();
        #12 sda_o = 1'b1;
        #12 scl_o = 1'b1;
        #16 sda_o = 1'b0;
        #16 scl_o = 1'b0;
    endtask
    task automatic sp();
        #12 sda_o = 1'b0;
        #12 scl_o = 1'b1;
        #16 sda_o = 1'b1;
        #16;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] q;
        st();
        by({ADDR, 1'b0}, q);
        by(c, q);
        by(d, q);
        sp();
    endtask
    // read byte, last byte not acked
    task automatic rd(input logic [7:0] c, output logic [7:0] q);
        st();
        by({ADDR, 1'b0}, q);
        by(c, q);
        st();
        by({ADDR, 1'b1}, q);
        by(8'hFF, q);
        sp();
    endtask
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        done = 1'b0;
    logic        open = 1'b0;
    logic [11:0] temp = 12'h000;
    logic        scl, sda_h, sd_o, sd_oe, al_o, al_oe, ot_o, ot_oe, m_st;
    logic [2:0]  m_ch;
    logic [7:0]  v;
    int          mismatches = 0;
    int          checks_done = 0;
    logic [15:0] rows [16] = '{16'h0100, 16'h0700, 16'h0900, 16'h0A5C,
        16'h1564, 16'h116E, 16'h127F, 16'h1364, 16'h1464, 16'h175A,
        16'h216E, 16'h247F, 16'h4100, 16'h4300, 16'h4400, 16'h4600};
    // wired data line with pull-up
    wire         sda = sda_h & ~sd_oe;
    always #2 clock_i = ~clock_i;
    // front end answers each start on the next edge
    always @(posedge clock_i) done <= m_st;
    tm_smbus_regs #(.MAKER_CODE(8'h5C), .TOUT_CYC(2000), .FAULT_CYC(50))
    tm_smbus_regs_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .smb_clk_i(scl), .smb_data_i(sda), .smb_data_o(sd_o),
        .smb_data_oe_o(sd_oe), .alert_o(al_o), .alert_oe_o(al_oe),
        .over_temp_out_o(ot_o), .over_temp_out_oe_o(ot_oe),
        .meas_start_o(m_st), .meas_chan_o(m_ch), .meas_done_i(done),
        .meas_value_i(temp), .meas_open_i(open && !m_ch[1]),
        .meas_short_i(open && m_ch[1]));
    tm_host host_i (.scl_o(scl), .sda_o(sda_h), .sda_i(sda));
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // new reading, then room for a full sweep of channels
    task automatic meas(input logic [11:0] t, input logic o);
        @(posedge clock_i);
        temp <= t;
        open <= o;
        repeat (400) @(posedge clock_i);
        // leave off the edge so outputs are settled when compared
        @(negedge clock_i);
    endtask
    // hang guard
    initial begin
        repeat (60000) @(posedge clock_i);
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        @(negedge clock_i);
        foreach (rows[i]) begin
            host_i.rd(rows[i][15:8], v);
            check(v, rows[i][7:0]);
        end
        $display("test reset values done");
        host_i.wr(8'h17, 8'h1E);
        host_i.wr(8'h01, 8'hAA);
        host_i.rd(8'h17, v);
        check(v, 8'h1E);
        host_i.rd(8'h01, v);
        check(v, 8'h00);
        meas(12'h7F8, 1'b0);
        host_i.rd(8'h07, v);
        check(v, 8'h7F);
        check({6'h00, al_oe, ot_oe}, 8'h03);
        host_i.wr(8'h42, 8'hFF);
        host_i.rd(8'h44, v);
        meas(12'hF00, 1'b0);
        host_i.rd(8'h02, v);
        check(v, 8'h00);
        check({6'h00, al_oe, ot_oe}, 8'h00);
        $display("test alarms done");
        meas(12'h0A3, 1'b0);
        host_i.rd(8'h09, v);
        check(v, 8'h60);
        meas(12'h0E0, 1'b0);
        host_i.rd(8'h01, v);
        check(v, 8'h14);
        host_i.wr(8'h41, 8'h80);
        meas(12'h000, 1'b0);
        host_i.rd(8'h07, v);
        check(v, 8'h1C);
        host_i.wr(8'h41, 8'h40);
        host_i.rd(8'h17, v);
        check(v, 8'h5A);
        host_i.wr(8'h42, 8'h00);
        host_i.rd(8'h44, v);
        meas(12'h000, 1'b1);
        host_i.rd(8'h03, v);
        check(v, 8'hFF);
        host_i.rd(8'h46, v);
        check({7'h00, |v}, 8'h01);
        check({3'h0, sd_o, ot_o, al_o, al_oe, ot_oe}, 8'h00);
        $display("test fault done");
        finish_test();
    end
endmodule
